// ---- hdl/pci_reset_and_subsystem_id_straps.sv ----
// host reset handling, open-drain interrupt request and subsystem id strap capture
// Operation
// R01: while host reset is low every output pin enable is off.
// R02: reset low-to-high release starts a full internal initialisation.
// R03: host keeps reset low at least three clocks before release.
// R04: interrupt pulls its open-drain line low, never drives it high.
// R05: vendor id low byte comes from the luminance/red video lines.
// R06: subsystem id low byte comes from the chrominance/green video lines.
// R07: vendor id high byte comes from the auxiliary data bus lines.
// R08: straps sampled while pins float in reset, held until next reset.
`timescale 1ns/10ps
`include "strap_defines.svh"

module pci_reset_and_subsystem_id_straps
  import strap_pkg::*;
#(
  parameter int MISC_W      = 16,
  parameter int INIT_CYCLES = `INIT_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              host_bus_reset_in_n,
  input  wire logic [7:0]        luma_red_lines_i,
  output logic      [7:0]        luma_red_lines_o,
  output logic                   luma_red_lines_oe,
  input  wire logic [7:0]        chroma_green_lines_i,
  output logic      [7:0]        chroma_green_lines_o,
  output logic                   chroma_green_lines_oe,
  input  wire logic [7:0]        aux_bus_data_lines_i,
  output logic      [7:0]        aux_bus_data_lines_o,
  output logic                   aux_bus_data_lines_oe,
  output logic      [MISC_W-1:0] misc_out_pins,
  output logic                   misc_out_pins_oe,
  output logic                   intr_req_a_n_o,
  output logic                   intr_req_a_n_oe,
  input  wire logic [7:0]        luma_out_data,
  input  wire logic              luma_out_en,
  input  wire logic [7:0]        chroma_out_data,
  input  wire logic              chroma_out_en,
  input  wire logic [7:0]        aux_out_data,
  input  wire logic              aux_out_en,
  input  wire logic [MISC_W-1:0] misc_out_data,
  input  wire logic              misc_out_en,
  input  wire logic              irq_request,
  output logic      [7:0]        luma_rx,
  output logic      [7:0]        chroma_rx,
  output logic      [7:0]        aux_rx,
  output logic                   core_reset,
  output logic                   straps_valid,
  output logic      [15:0]       subsys_vendor_id,
  output logic      [7:0]        subsys_id_low,
  output logic                   reset_too_short
);

  localparam int                      CNT_W   = `RESET_CNT_W;
  localparam logic [`RESET_CNT_W-1:0] CNT_MAX = {`RESET_CNT_W{1'b1}};
  localparam logic [`RESET_CNT_W-1:0] MIN_LOW = `RESET_CNT_W'(`RESET_MIN_CLOCKS);
  localparam logic [`RESET_CNT_W-1:0] INIT_LAST = `RESET_CNT_W'(INIT_CYCLES - 1);
  localparam int                      LANE_W  = `STRAP_LANE_W;
  localparam int                      LANES   = `STRAP_LANES;

  typedef struct packed {
    reset_state_type   state;
    logic [CNT_W-1:0]  low_cnt;
    logic [CNT_W-1:0]  init_cnt;
    logic              short_flag;
    logic              valid;
    logic [7:0]        luma_o;
    logic [7:0]        chroma_o;
    logic [7:0]        aux_o;
    logic [MISC_W-1:0] misc_o;
    logic [7:0]        luma_rx;
    logic [7:0]        chroma_rx;
    logic [7:0]        aux_rx;
  } ctl_state_type;

  ctl_state_type            ctl_q;
  ctl_state_type            ctl_d;
  logic                     running;
  logic                     strap_sample;
  logic [LANES*LANE_W-1:0]  strap_pins;
  logic [LANES*LANE_W-1:0]  strap_bytes;

  generate
    if (MISC_W < 1) begin : g_bad_misc
      $error("pci_reset_and_subsystem_id_straps: MISC_W must be at least 1");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > (1 << `RESET_CNT_W)) begin : g_bad_init
      $error("pci_reset_and_subsystem_id_straps: INIT_CYCLES out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  // sample only while reset holds the pins floating, so board pulls set the level
  assign strap_sample = (ctl_q.state == ST_IN_RESET) && !host_bus_reset_in_n; // R08

  always_comb begin
    strap_pins = '0;
    strap_pins[`LANE_VENDOR_LO*LANE_W +: LANE_W] = luma_red_lines_i;     // R05
    strap_pins[`LANE_SUBSYS_LO*LANE_W +: LANE_W] = chroma_green_lines_i; // R06
    strap_pins[`LANE_VENDOR_HI*LANE_W +: LANE_W] = aux_bus_data_lines_i; // R07
  end

  strap_capture #(
    .LANES (LANES),
    .WIDTH (LANE_W)
  ) u_strap_capture (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .sample   (strap_sample),
    .lanes_in (strap_pins),
    .lanes_q  (strap_bytes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing

  always_comb begin
    ctl_d = ctl_q;
    case (ctl_q.state)
      ST_IN_RESET: begin
        if (!host_bus_reset_in_n) begin
          if (ctl_q.low_cnt != CNT_MAX) begin
            ctl_d.low_cnt = ctl_q.low_cnt + 1'b1;
          end
        end else begin
          // release edge: start initialising, straps now frozen
          ctl_d.state      = ST_INIT; // R02
          ctl_d.init_cnt   = '0;
          ctl_d.valid      = 1'b1;
          // a too-short pulse is still honoured, but reported
          ctl_d.short_flag = (ctl_q.low_cnt < MIN_LOW); // R03
        end
      end
      ST_INIT: begin
        if (ctl_q.init_cnt == INIT_LAST) begin
          ctl_d.state = ST_RUN;
        end else begin
          ctl_d.init_cnt = ctl_q.init_cnt + 1'b1;
        end
      end
      ST_RUN: begin
        ctl_d.state = ST_RUN;
      end
      default: begin
        ctl_d.state = ST_IN_RESET;
      end
    endcase

    // a new reset pulse overrides the sequencer state, counters and flags, from ST_INIT or ST_RUN
    if (!host_bus_reset_in_n && ctl_q.state != ST_IN_RESET) begin
      ctl_d.state      = ST_IN_RESET; // R02
      ctl_d.low_cnt    = `RESET_CNT_W'(1);
      ctl_d.init_cnt   = '0;
      ctl_d.valid      = 1'b0;
      ctl_d.short_flag = 1'b0;
    end

    // pin data registers; cleared outside ST_RUN so nothing stale drives out
    if (ctl_q.state == ST_RUN) begin
      ctl_d.luma_o    = luma_out_data;
      ctl_d.chroma_o  = chroma_out_data;
      ctl_d.aux_o     = aux_out_data;
      ctl_d.misc_o    = misc_out_data;
      ctl_d.luma_rx   = luma_red_lines_i;
      ctl_d.chroma_rx = chroma_green_lines_i;
      ctl_d.aux_rx    = aux_bus_data_lines_i;
    end else begin
      ctl_d.luma_o    = `PIN_RESET_VALUE;
      ctl_d.chroma_o  = `PIN_RESET_VALUE;
      ctl_d.aux_o     = `PIN_RESET_VALUE;
      ctl_d.misc_o    = '0;
      ctl_d.luma_rx   = `PIN_RESET_VALUE;
      ctl_d.chroma_rx = `PIN_RESET_VALUE;
      ctl_d.aux_rx    = `PIN_RESET_VALUE;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q.state      <= ST_IN_RESET;
      ctl_q.low_cnt    <= '0;
      ctl_q.init_cnt   <= '0;
      ctl_q.short_flag <= 1'b0;
      ctl_q.valid      <= 1'b0;
      ctl_q.luma_o     <= `PIN_RESET_VALUE;
      ctl_q.chroma_o   <= `PIN_RESET_VALUE;
      ctl_q.aux_o      <= `PIN_RESET_VALUE;
      ctl_q.misc_o     <= '0;
      ctl_q.luma_rx    <= `PIN_RESET_VALUE;
      ctl_q.chroma_rx  <= `PIN_RESET_VALUE;
      ctl_q.aux_rx     <= `PIN_RESET_VALUE;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // gated by the reset pin itself so the pins float in the very cycle it drops
  assign running = (ctl_q.state == ST_RUN) && host_bus_reset_in_n; // R01

  assign luma_red_lines_o      = ctl_q.luma_o;
  assign luma_red_lines_oe     = running && luma_out_en;   // R01
  assign chroma_green_lines_o  = ctl_q.chroma_o;
  assign chroma_green_lines_oe = running && chroma_out_en; // R01
  assign aux_bus_data_lines_o  = ctl_q.aux_o;
  assign aux_bus_data_lines_oe = running && aux_out_en;    // R01
  assign misc_out_pins         = ctl_q.misc_o;
  assign misc_out_pins_oe      = running && misc_out_en;   // R01

  // open drain: only ever pulls low, released when nothing is pending
  assign intr_req_a_n_o  = 1'b0;                  // R04
  assign intr_req_a_n_oe = running && irq_request; // R04

  ////////////////////////////////////////////////////////////////////////////
  // core side

  assign core_reset       = (ctl_q.state != ST_RUN); // R02
  assign straps_valid     = ctl_q.valid;
  assign subsys_vendor_id = {strap_bytes[`LANE_VENDOR_HI*LANE_W +: LANE_W],
                             strap_bytes[`LANE_VENDOR_LO*LANE_W +: LANE_W]}; // R05 R07
  assign subsys_id_low    = strap_bytes[`LANE_SUBSYS_LO*LANE_W +: LANE_W]; // R06
  assign reset_too_short  = ctl_q.short_flag;
  assign luma_rx          = ctl_q.luma_rx;
  assign chroma_rx        = ctl_q.chroma_rx;
  assign aux_rx           = ctl_q.aux_rx;

endmodule

// ---- hdl/README_unused.sv ----
// holds no logic
`timescale 1ns/10ps

// ---- hdl/strap_capture.sv ----
// per-lane strap sampling registers, held once sampling stops
`timescale 1ns/10ps
`include "strap_defines.svh"

module strap_capture
  import strap_pkg::*;
#(
  parameter int LANES = `STRAP_LANES,
  parameter int WIDTH = `STRAP_LANE_W
) (
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   sample,
  input  wire logic [LANES*WIDTH-1:0] lanes_in,
  output logic      [LANES*WIDTH-1:0] lanes_q
);

  typedef struct packed {
    logic [LANES*WIDTH-1:0] bytes;
  } cap_state_type;

  cap_state_type                  cap_q;
  cap_state_type                  cap_d;
  logic          [LANES*WIDTH-1:0] lanes_next;

  generate
    if (LANES < 1 || WIDTH < 1) begin : g_bad_size
      $error("strap_capture: LANES and WIDTH must be at least 1");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // one sampler per lane
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      assign lanes_next[lane*WIDTH +: WIDTH] = sample ?
        lanes_in[lane*WIDTH +: WIDTH] : cap_q.bytes[lane*WIDTH +: WIDTH]; // R08
    end
  endgenerate

  always_comb begin
    cap_d       = cap_q;
    cap_d.bytes = lanes_next;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_q.bytes <= {LANES{WIDTH'(`STRAP_RESET_VALUE)}};
    end else begin
      cap_q <= cap_d;
    end
  end

  assign lanes_q = cap_q.bytes;

endmodule

// ---- hdl/strap_defines.svh ----
// constants for the host reset and subsystem id strap logic
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH

// least host reset low time, in host clock periods
`define RESET_MIN_CLOCKS   3
// internal initialisation pulse after reset release, in clock cycles
`define INIT_CYCLES        4
// width of the reset and init counters
`define RESET_CNT_W        4
// strap lane positions inside the capture word
`define LANE_VENDOR_LO     0
`define LANE_SUBSYS_LO     1
`define LANE_VENDOR_HI     2
`define STRAP_LANES        3
`define STRAP_LANE_W       8
// reset values
`define STRAP_RESET_VALUE  8'h00
`define PIN_RESET_VALUE    8'h00

`endif

// ---- hdl/strap_pkg.sv ----
// types shared by the strap logic
package strap_pkg;

  typedef enum logic [2:0] {
    ST_IN_RESET = 3'b001,
    ST_INIT     = 3'b010,
    ST_RUN      = 3'b100
  } reset_state_type;

endpackage

// ---- sim/host_model.sv ----
// host side model: bus reset driver and pulled-up interrupt wire
`timescale 1ns/10ps
module host_model (
  input  wire logic sys_clk,
  input  wire logic intr_n_o,
  input  wire logic intr_n_oe,
  output logic      rst_n,
  output logic      intr_line
);
  // board pull-up holds the wire high when nobody sinks it
  assign intr_line = intr_n_oe ? intr_n_o : 1'b1;
  initial rst_n = 1'b0;
  ////////////////////////////////////////////////////////////////
  task automatic pulse(input int n);
    @(negedge sys_clk) rst_n <= 1'b0;
    // low for n clocks; callers pass 3 or more except to test a short one
    repeat (n) @(negedge sys_clk);
    rst_n <= 1'b1;
  endtask
endmodule

// ---- sim/strap_chk.sv ----
// assertions on the host reset, interrupt and strap ports
`timescale 1ns/10ps
module strap_chk #(
  parameter int MISC_W      = 16,
  parameter int INIT_CYCLES = 4
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        host_bus_reset_in_n,
  input wire logic [7:0]  luma_red_lines_i,
  input wire logic [7:0]  chroma_green_lines_i,
  input wire logic [7:0]  aux_bus_data_lines_i,
  input wire logic        luma_red_lines_oe,
  input wire logic        chroma_green_lines_oe,
  input wire logic        aux_bus_data_lines_oe,
  input wire logic        misc_out_pins_oe,
  input wire logic        intr_req_a_n_o,
  input wire logic        intr_req_a_n_oe,
  input wire logic        irq_request,
  input wire logic        core_reset,
  input wire logic        straps_valid,
  input wire logic [15:0] subsys_vendor_id,
  input wire logic [7:0]  subsys_id_low
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence rel_s;
    $rose(host_bus_reset_in_n);
  endsequence
  // only captures preceded by two low edges are fully sampled
  sequence cap_s;
    $rose(straps_valid) && !$past(host_bus_reset_in_n, 2) && !$past(host_bus_reset_in_n, 3);
  endsequence
  ////////////////////////////////////////////////////////////////
  oe_off_a:
    assert property (!host_bus_reset_in_n |-> !(luma_red_lines_oe || chroma_green_lines_oe
      || aux_bus_data_lines_oe || misc_out_pins_oe || intr_req_a_n_oe)) else $error("pin on");
  intr_low_a:
    assert property (intr_req_a_n_oe |-> !intr_req_a_n_o) else $error("irq high");
  intr_req_a:
    assert property (intr_req_a_n_oe == (irq_request && host_bus_reset_in_n && !core_reset))
      else $error("irq enable");
  init_len_a:
    assert property (rel_s |-> core_reset[*5] ##1 !core_reset) else $error("init length");
  hold_a:
    assert property (straps_valid && $past(straps_valid) |-> $stable(subsys_vendor_id)
      && $stable(subsys_id_low)) else $error("straps moved");
  vend_lo_a:
    assert property (cap_s |-> subsys_vendor_id[7:0] == $past(luma_red_lines_i, 2))
      else $error("vendor low");
  sub_lo_a:
    assert property (cap_s |-> subsys_id_low == $past(chroma_green_lines_i, 2))
      else $error("subsystem low");
  vend_hi_a:
    assert property (cap_s |-> subsys_vendor_id[15:8] == $past(aux_bus_data_lines_i, 2))
      else $error("vendor high");
endmodule
bind pci_reset_and_subsystem_id_straps strap_chk #(.MISC_W(MISC_W), .INIT_CYCLES(INIT_CYCLES))
  strap_chk_i (.*);

// ---- sim/tb.sv ----
// testbench: host resets, strap capture and pin drive
`timescale 1ns/10ps
module tb;
  logic        sys_clk, sys_rst, host_bus_reset_in_n, intr_line, v_q;
  logic [7:0]  luma_red_lines_i, luma_red_lines_o, chroma_green_lines_i, chroma_green_lines_o;
  logic [7:0]  aux_bus_data_lines_i, aux_bus_data_lines_o, luma_out_data, chroma_out_data;
  logic [7:0]  aux_out_data, subsys_id_low, l_pull, c_pull, a_pull;
  logic [7:0]  luma_rx, chroma_rx, aux_rx;
  logic [23:0] pin_exp;
  logic        luma_red_lines_oe, chroma_green_lines_oe, aux_bus_data_lines_oe;
  logic        misc_out_pins_oe, intr_req_a_n_o, intr_req_a_n_oe, luma_out_en;
  logic        chroma_out_en, aux_out_en, misc_out_en, irq_request;
  logic        core_reset, straps_valid, reset_too_short;
  logic [15:0] misc_out_pins, misc_out_data, subsys_vendor_id;
  logic [23:0] exp_q[$];
  int          num_errors = 0, compares = 0, seed = 69, cyc = 0, n;

  // board pulls show through wherever the device lets go
  assign luma_red_lines_i     = luma_red_lines_oe ? luma_red_lines_o : l_pull;
  assign chroma_green_lines_i = chroma_green_lines_oe ? chroma_green_lines_o : c_pull;
  assign aux_bus_data_lines_i = aux_bus_data_lines_oe ? aux_bus_data_lines_o : a_pull;

  pci_reset_and_subsystem_id_straps pci_reset_and_subsystem_id_straps_i (.*);
  host_model host_model_i (
    .sys_clk   (sys_clk),
    .intr_n_o  (intr_req_a_n_o),
    .intr_n_oe (intr_req_a_n_oe),
    .rst_n     (host_bus_reset_in_n),
    .intr_line (intr_line)
  );
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  // empty queue expects unknown, so a stray capture always mismatches
  always @(negedge sys_clk) begin
    if (straps_valid === 1'b1 && v_q !== 1'b1)
      check({subsys_vendor_id, subsys_id_low}, exp_q.size() ? exp_q.pop_front() : 'x);
    v_q = straps_valid;
  end

  initial begin
    sys_rst = 1'b1;
    {l_pull, c_pull, a_pull, luma_out_data, chroma_out_data, aux_out_data} = '0;
    {luma_out_en, chroma_out_en, aux_out_en, misc_out_en, irq_request} = '0;
    misc_out_data = '0;
    repeat (12) @(negedge sys_clk);
    sys_rst = 1'b0;
    for (int k = 0; k < 5; k++) begin
      n = (k == 1) ? 2 : 4 + k;
      {l_pull, c_pull, a_pull} = 24'($random(seed));
      {luma_out_en, chroma_out_en, aux_out_en, misc_out_en, irq_request} = 5'h1f;
      exp_q.push_back({a_pull, l_pull, c_pull});
      fork
        host_model_i.pulse(n);
        begin
          repeat (2) @(negedge sys_clk);
          #1;
          check({luma_red_lines_i, chroma_green_lines_i, aux_bus_data_lines_i}, {l_pull, c_pull, a_pull});
          check({intr_line, misc_out_pins_oe}, 24'h00_0002);
        end
      join
      repeat (10) @(negedge sys_clk);
      check(reset_too_short, n < 3);
      check(core_reset, 24'h00_0000);
      for (int j = 0; j < 3; j++) begin
        {luma_out_data, chroma_out_data, aux_out_data} = 24'($random(seed));
        {misc_out_data, l_pull, c_pull} = $random(seed);
        {a_pull, luma_out_en, chroma_out_en, aux_out_en, misc_out_en, irq_request} =
          13'($random(seed));
        @(negedge sys_clk);
        #1;
        pin_exp = {luma_out_en ? luma_out_data : l_pull, chroma_out_en ? chroma_out_data : c_pull,
                   aux_out_en ? aux_out_data : a_pull};
        check({luma_red_lines_i, chroma_green_lines_i, aux_bus_data_lines_i}, pin_exp);
        check({misc_out_pins, misc_out_pins_oe, intr_line}, {misc_out_data, misc_out_en, ~irq_request});
        // shared lines read back one cycle later while inputs stand
        @(negedge sys_clk);
        #1;
        check({luma_rx, chroma_rx, aux_rx}, pin_exp);
      end
      $display("reset test %0d done", k);
    end
    // every noted capture must have been seen
    check(24'(exp_q.size()), 24'h00_0000);
    wrap_up();
  end
endmodule
